// ===== sfp_port.sv
// sfp_port: slave serial port of a paged flash with write unlock,
// status byte, page buffer and self-timed page cycle.
// assumes the array controller reads the page buffer while busy_out is high.
//
// Functional notes
// - outgoing data bits change on falling serial clock edges.
// - incoming bits sampled on rising serial clock edges.
// - select high deselects and floats the serial output.
// - deselected and idle means standby; select low means active.
// - no command decoded until a select falling edge has been seen.
// - reset low holds reset state with output floating.
// - reset during an internal cycle aborts it.
// - write-protect low freezes block protect bits when freeze bit set.
// - both clock modes 0 and 3 work; rise captures, fall launches.
// - up to 256 data bytes, wrapping inside one page.
// - burn only clears bits; rewrite sets bits either way.
// - accepted page command runs a self-timed rewrite or burn cycle.
// - modifying commands need a clock count that is a multiple of eight.
// - modifying commands need the unlock latch; latch clears at reset and completion.
// - page cycle starts at select rise after command, address and data.
`timescale 1ns/10ps
module sfp_port #(
	parameter int REWRITE_TIME_US = 10000,
	parameter int BURN_TIME_US = 1000
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic serial_in,
	input wire logic wp_n_in,
	input wire logic [7:0] buf_rd_addr_in,
	output logic serial_out,
	output logic serial_oe_n_out,
	output logic standby_out,
	output logic busy_out,
	output sfp_pkg::sfp_commit_s commit_out,
	output sfp_pkg::sfp_buf_s buf_rd_out
);
	import sfp_pkg::*;

	localparam int REWRITE_CYC = REWRITE_TIME_US * SFP_CLK_MHZ;
	localparam int BURN_CYC = BURN_TIME_US * SFP_CLK_MHZ;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [SFP_PINS-1:0] pin_raw;
	logic [SFP_PINS-1:0] sync1;
	logic [SFP_PINS-1:0] sync2;
	logic [SFP_PINS-1:0] sync3;
	logic [SFP_PINS-1:0] pin_lvl;

	assign pin_raw = {wp_n_in, serial_in, sel_n_in, sclk_in};

	genvar gi;
	generate
		for (gi = 0; gi < SFP_PINS; gi++) begin : g_sync
			// a level only counts once two late stages agree, filtering one-cycle glitches
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					sync1[gi] <= SFP_PIN_RST[gi];
					sync2[gi] <= SFP_PIN_RST[gi];
					sync3[gi] <= SFP_PIN_RST[gi];
					pin_lvl[gi] <= SFP_PIN_RST[gi];
				end else begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi]) begin
						pin_lvl[gi] <= sync3[gi];
					end
				end
			end
		end
	endgenerate

	function automatic logic rises(input int idx, input logic [SFP_PINS-1:0] s2,
			input logic [SFP_PINS-1:0] s3, input logic [SFP_PINS-1:0] lvl);
		rises = s2[idx] && s3[idx] && !lvl[idx];
	endfunction

	function automatic logic falls(input int idx, input logic [SFP_PINS-1:0] s2,
			input logic [SFP_PINS-1:0] s3, input logic [SFP_PINS-1:0] lvl);
		falls = !s2[idx] && !s3[idx] && lvl[idx];
	endfunction

	logic clk_rise;
	logic clk_fall;
	logic sel_fall;
	logic sel_rise;
	logic din;

	// both clock modes look alike here: only edges inside a frame matter
	assign clk_rise = rises(SFP_PIN_SCLK, sync2, sync3, pin_lvl);
	assign clk_fall = falls(SFP_PIN_SCLK, sync2, sync3, pin_lvl);
	assign sel_fall = falls(SFP_PIN_SEL, sync2, sync3, pin_lvl);
	assign sel_rise = rises(SFP_PIN_SEL, sync2, sync3, pin_lvl);
	assign din = pin_lvl[SFP_PIN_DIN];

	// ---------------------------------------------------------------
	// framing
	// ---------------------------------------------------------------
	logic armed;
	logic live;
	logic [2:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic [7:0] shift_in;
	logic [7:0] next_byte;
	logic byte_done;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [7:0] wrsr_data;
	logic [7:0] ptr;
	logic page_cmd;

	// a select already low at reset release reads as a falling edge and arms the port
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			armed <= 1'b0;
		end else if (sel_fall) begin
			armed <= 1'b1;
		end
	end

	assign live = armed && !pin_lvl[SFP_PIN_SEL];
	assign next_byte = {shift_in[6:0], din};
	assign byte_done = live && clk_rise && (bit_cnt == SFP_LAST_BIT);
	assign page_cmd = (opcode == SFP_OP_REWRITE) || (opcode == SFP_OP_BURN);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bit_cnt <= 3'h0;
			shift_in <= 8'h00;
		end else if (sel_fall) begin
			bit_cnt <= 3'h0;
		end else if (live && clk_rise) begin
			shift_in <= next_byte;
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// byte count saturates once data has begun
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			byte_cnt <= 3'h0;
			opcode <= 8'h00;
			addr <= 24'h000000;
			wrsr_data <= 8'h00;
		end else if (sel_fall) begin
			byte_cnt <= 3'h0;
			opcode <= 8'h00;
		end else if (byte_done) begin
			if (byte_cnt != SFP_MIN_PAGE) begin
				byte_cnt <= byte_cnt + 3'h1;
			end
			if (byte_cnt == 3'h0) begin
				opcode <= next_byte;
			end else if (byte_cnt < SFP_BYTE_DATA) begin
				addr <= {addr[15:0], next_byte};
			end
			if (byte_cnt == SFP_BYTE_WRSR) begin
				wrsr_data <= next_byte;
			end
		end
	end

	// ---------------------------------------------------------------
	// page buffer
	// ---------------------------------------------------------------
	logic [7:0] page_buf [SFP_PAGE_BYTES];
	logic [SFP_PAGE_BYTES-1:0] mark;
	sfp_cyc_e cyc;

	// pointer wraps inside the page, so extra bytes overwrite earlier ones
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ptr <= 8'h00;
			mark <= '0;
		end else if (byte_done && cyc == SFP_CYC_IDLE) begin
			if (byte_cnt == SFP_BYTE_ADDR_LO) begin
				ptr <= next_byte;
				mark <= '0;
			end else if (byte_cnt >= SFP_BYTE_DATA && page_cmd) begin
				mark[ptr] <= 1'b1;
				ptr <= ptr + 8'h01;
			end
		end
	end

	// memory has no reset: unmarked bytes are never used
	always_ff @(posedge clk_in) begin
		if (byte_done && cyc == SFP_CYC_IDLE && byte_cnt >= SFP_BYTE_DATA && page_cmd) begin
			page_buf[ptr] <= next_byte;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			buf_rd_out <= '0;
		end else begin
			buf_rd_out <= '{mark: mark[buf_rd_addr_in], data: page_buf[buf_rd_addr_in]};
		end
	end

	// ---------------------------------------------------------------
	// command acceptance and internal cycle
	// ---------------------------------------------------------------
	logic whole_bytes;
	logic unlock;
	logic [7:0] status;
	logic [23:0] timer;
	logic accept_page;
	logic accept_wrsr;
	logic frozen;

	// partial bytes void any modifying command
	assign whole_bytes = (bit_cnt == 3'h0);
	assign frozen = status[SFP_ST_FREEZE] && !pin_lvl[SFP_PIN_WP];
	assign accept_page = sel_rise && armed && whole_bytes && unlock && cyc == SFP_CYC_IDLE
		&& page_cmd && byte_cnt >= SFP_MIN_PAGE;
	assign accept_wrsr = sel_rise && armed && whole_bytes && unlock && cyc == SFP_CYC_IDLE
		&& opcode == SFP_OP_WR_STATUS && byte_cnt >= SFP_MIN_WRSR && !frozen;

	// reset clears the latch and aborts any cycle in flight
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cyc <= SFP_CYC_IDLE;
			timer <= 24'h000000;
		end else if (accept_page) begin
			// rewrite erases then programs, burn only clears bits
			if (opcode == SFP_OP_REWRITE) begin
				cyc <= SFP_CYC_REWRITE;
				timer <= 24'(REWRITE_CYC - 1);
			end else begin
				cyc <= SFP_CYC_BURN;
				timer <= 24'(BURN_CYC - 1);
			end
		end else if (cyc != SFP_CYC_IDLE) begin
			if (timer == 24'h000000) begin
				cyc <= SFP_CYC_IDLE;
			end else begin
				timer <= timer - 24'h000001;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			unlock <= 1'b0;
		end else if (sel_rise && armed && whole_bytes && byte_cnt == SFP_MIN_UNLOCK
				&& cyc == SFP_CYC_IDLE && opcode == SFP_OP_UNLOCK) begin
			unlock <= 1'b1;
		end else if (accept_wrsr || (cyc != SFP_CYC_IDLE && timer == 24'h000000)) begin
			unlock <= 1'b0;
		end else if (sel_rise && armed && whole_bytes && byte_cnt == SFP_MIN_UNLOCK
				&& cyc == SFP_CYC_IDLE && opcode == SFP_OP_RELOCK) begin
			unlock <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status <= SFP_STATUS_RST;
		end else if (accept_wrsr) begin
			status[SFP_ST_FREEZE] <= wrsr_data[SFP_ST_FREEZE];
			status[SFP_ST_BP_HI:SFP_ST_BP_LO] <= wrsr_data[SFP_ST_BP_HI:SFP_ST_BP_LO];
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			commit_out <= '0;
		end else begin
			commit_out.strobe <= accept_page;
			if (accept_page) begin
				commit_out.rewrite <= (opcode == SFP_OP_REWRITE);
				commit_out.page <= addr[23:8];
			end
		end
	end

	// ---------------------------------------------------------------
	// serial output and power state
	// ---------------------------------------------------------------
	logic [7:0] out_sh;
	logic [7:0] status_view;

	always_comb begin
		status_view = status;
		status_view[SFP_ST_BUSY] = (cyc != SFP_CYC_IDLE);
		status_view[SFP_ST_UNLOCK] = unlock;
	end

	// status repeats every byte while the read lasts
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			out_sh <= 8'h00;
			serial_out <= 1'b0;
		end else if (byte_done && (byte_cnt == 3'h0 ? next_byte : opcode) == SFP_OP_RD_STATUS) begin
			out_sh <= status_view;
		end else if (live && clk_fall) begin
			serial_out <= out_sh[7];
			out_sh <= {out_sh[6:0], 1'b0};
		end
	end

	// float whenever deselected or not yet armed
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			serial_oe_n_out <= 1'b1;
		end else begin
			serial_oe_n_out <= !(live && opcode == SFP_OP_RD_STATUS);
		end
	end

	// standby waits for the internal cycle to finish
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			standby_out <= 1'b1;
			busy_out <= 1'b0;
		end else begin
			standby_out <= pin_lvl[SFP_PIN_SEL] && cyc == SFP_CYC_IDLE;
			busy_out <= (cyc != SFP_CYC_IDLE);
		end
	end

endmodule

// ===== sfp_pkg.sv
// sfp_pkg: constants and types for the serial flash port.
// assumes a 10 MHz system clock and a slow, externally driven serial clock.
package sfp_pkg;

	// ---------------------------------------------------------------
	// clocking and pin sampling
	// ---------------------------------------------------------------
	localparam int SFP_CLK_MHZ = 10;
	localparam int SFP_PINS = 4;
	localparam int SFP_PIN_SCLK = 0;
	localparam int SFP_PIN_SEL = 1;
	localparam int SFP_PIN_DIN = 2;
	localparam int SFP_PIN_WP = 3;
	// idle pin levels: clock low, select high, data low, write-protect high
	localparam logic [SFP_PINS-1:0] SFP_PIN_RST = 4'hA;

	// ---------------------------------------------------------------
	// command codes
	// ---------------------------------------------------------------
	localparam logic [7:0] SFP_OP_UNLOCK = 8'h06;
	localparam logic [7:0] SFP_OP_RELOCK = 8'h04;
	localparam logic [7:0] SFP_OP_RD_STATUS = 8'h05;
	localparam logic [7:0] SFP_OP_WR_STATUS = 8'h01;
	localparam logic [7:0] SFP_OP_REWRITE = 8'h0A;
	localparam logic [7:0] SFP_OP_BURN = 8'h02;

	// ---------------------------------------------------------------
	// status byte layout
	// ---------------------------------------------------------------
	localparam int SFP_ST_BUSY = 0;
	localparam int SFP_ST_UNLOCK = 1;
	localparam int SFP_ST_BP_LO = 2;
	localparam int SFP_ST_BP_HI = 4;
	localparam int SFP_ST_FREEZE = 7;
	localparam logic [7:0] SFP_STATUS_RST = 8'h00;

	// ---------------------------------------------------------------
	// framing
	// ---------------------------------------------------------------
	localparam logic [2:0] SFP_LAST_BIT = 3'h7;
	localparam logic [2:0] SFP_BYTE_WRSR = 3'h1;
	localparam logic [2:0] SFP_BYTE_ADDR_LO = 3'h3;
	localparam logic [2:0] SFP_BYTE_DATA = 3'h4;
	localparam logic [2:0] SFP_MIN_UNLOCK = 3'h1;
	localparam logic [2:0] SFP_MIN_WRSR = 3'h2;
	localparam logic [2:0] SFP_MIN_PAGE = 3'h5;
	localparam int SFP_PAGE_BYTES = 256;

	typedef enum logic [1:0] {
		SFP_CYC_IDLE = 2'b00,
		SFP_CYC_REWRITE = 2'b01,
		SFP_CYC_BURN = 2'b10
	} sfp_cyc_e;

	// page commit handed to the array controller
	typedef struct packed {
		logic strobe;
		logic rewrite;
		logic [15:0] page;
	} sfp_commit_s;

	// one page buffer entry: mark says the byte was sent in the frame
	typedef struct packed {
		logic mark;
		logic [7:0] data;
	} sfp_buf_s;

endpackage

// ===== sfp_port_props.sv
// sfp_port_props: port checker for the serial flash port.
// assumes the 10 MHz clock and serial half periods of 4 cycles or more.
`timescale 1ns/10ps
module sfp_port_props import sfp_pkg::*; #(
	parameter int REWRITE_TIME_US = 10000,
	parameter int BURN_TIME_US = 1000
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic serial_out,
	input wire logic serial_oe_n_out,
	input wire logic standby_out,
	input wire logic busy_out,
	input wire sfp_pkg::sfp_commit_s commit_out
);
	// ----
	// busy length helper
	// ----
	int busy_cnt;
	int busy_lim;
	logic was_rewrite;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) busy_cnt <= 0;
		else busy_cnt <= busy_out ? busy_cnt + 1 : 0;
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) was_rewrite <= 1'b0;
		else if (commit_out.strobe) was_rewrite <= commit_out.rewrite;
	end
	assign busy_lim = (was_rewrite ? REWRITE_TIME_US : BURN_TIME_US) * SFP_CLK_MHZ;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// ----
	// assertions
	// ----
	reset_state_a: assert property ($rose(nrst_in) |-> serial_oe_n_out && standby_out && !busy_out)
		else $error("outputs not in reset state");
	float_desel_a: assert property (sel_n_in [*8] |-> serial_oe_n_out)
		else $error("output driven while deselected");
	active_sel_a: assert property (!sel_n_in [*6] |-> !standby_out)
		else $error("standby while selected");
	standby_busy_a: assert property (busy_out |-> !standby_out)
		else $error("standby during cycle");
	strobe_busy_a: assert property (commit_out.strobe |=> busy_out && !commit_out.strobe)
		else $error("strobe not followed by busy");
	strobe_sel_a: assert property (commit_out.strobe |-> sel_n_in && $past(sel_n_in, 2))
		else $error("cycle start before select rise");
	out_edge_a: assert property (!serial_oe_n_out && $changed(serial_out) |-> !$past(sclk_in, 2))
		else $error("output moved off falling edge");
	busy_max_a: assert property (busy_out |-> busy_cnt <= busy_lim + 1)
		else $error("cycle too long");
	busy_min_a: assert property ($fell(busy_out) |-> busy_cnt >= busy_lim - 1)
		else $error("cycle too short");
endmodule
bind sfp_port sfp_port_props #(.REWRITE_TIME_US(REWRITE_TIME_US), .BURN_TIME_US(BURN_TIME_US)) sfp_port_props_i (
	.clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk_in), .sel_n_in(sel_n_in), .serial_out(serial_out),
	.serial_oe_n_out(serial_oe_n_out), .standby_out(standby_out), .busy_out(busy_out), .commit_out(commit_out));

// ===== sfp_master.sv
// sfp_master: behavioural serial master facing the flash port.
// assumes one frame task call at a time; line_in is the resolved data line.
`timescale 1ns/10ps
module sfp_master (
	input wire logic clk_in,
	input wire logic line_in,
	output logic sclk_out,
	output logic sel_n_out,
	output logic mosi_out,
	output logic [7:0] rd_byte_out,
	output logic [7:0] rd_cnt_out
);
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		mosi_out = 1'b0;
		rd_byte_out = 8'h00;
		rd_cnt_out = 8'h00;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	// 4 cycles a half period gives the 800 ns serial clock
	task automatic frame(input logic [63:0] b, input int nb, input int xb, input logic cpol, input logic rd);
		int i;
		logic [7:0] r;
		r = 8'h00;
		tick(4);
		sclk_out = cpol; // parked level of the mode
		tick(4);
		sel_n_out = 1'b0; // falling select opens every frame
		for (i = 0; i <= nb * 8 + xb; i++) begin
			tick(4);
			if (i > 0) begin
				r = {r[6:0], line_in};
				if (rd && i > 8 && i % 8 == 0) begin
					rd_byte_out = r;
					rd_cnt_out = rd_cnt_out + 8'h01;
				end
			end
			if (i == nb * 8 + xb) break;
			sclk_out = 1'b0;
			mosi_out = b[63 - i]; // msb first, eight clocks a byte
			tick(4);
			sclk_out = 1'b1;
		end
		if (!cpol) sclk_out = 1'b0;
		tick(4);
		sel_n_out = 1'b1;
		// released data line must not keep its level
		mosi_out = ~mosi_out;
	endtask
endmodule

// ===== sfp_port_tb.sv
// sfp_port_tb: self-checking bench for the serial flash port.
// assumes sfp_master drives the pins; cycle times shortened to 2 us and 1 us.
`timescale 1ns/10ps
module sfp_port_tb;
	import sfp_pkg::*;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic wp_n_in = 1'b1;
	logic [7:0] buf_rd_addr_in = 8'h00;
	logic sclk, sel_n, mosi, line, serial_out, serial_oe_n_out, standby_out, busy_out;
	logic last = 1'b0;
	logic [7:0] rd_byte, rd_cnt;
	logic [7:0] rd_seen = 8'h00;
	logic [7:0] rnd = 8'h43;
	logic [7:0] d [0:2];
	sfp_commit_s commit_out;
	sfp_buf_s buf_rd_out;
	logic [31:0] cq [$];
	logic [31:0] sq [$];
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	always #50 clk_in = ~clk_in;
	always @(posedge clk_in) if (serial_oe_n_out === 1'b0) last <= serial_out;
	assign line = serial_oe_n_out ? ~last : serial_out;
	sfp_port #(.REWRITE_TIME_US(2), .BURN_TIME_US(1)) sfp_port_i (.clk_in(clk_in), .nrst_in(nrst_in),
		.sclk_in(sclk), .sel_n_in(sel_n), .serial_in(mosi), .wp_n_in(wp_n_in), .buf_rd_addr_in(buf_rd_addr_in),
		.serial_out(serial_out), .serial_oe_n_out(serial_oe_n_out), .standby_out(standby_out),
		.busy_out(busy_out), .commit_out(commit_out), .buf_rd_out(buf_rd_out));
	sfp_master sfp_master_i (.clk_in(clk_in), .line_in(line), .sclk_out(sclk), .sel_n_out(sel_n),
		.mosi_out(mosi), .rd_byte_out(rd_byte), .rd_cnt_out(rd_cnt));
	// ----
	// helpers
	// ----
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic rdsr(input logic [7:0] exp, input logic m);
		sq.push_back(32'(exp));
		sq.push_back(32'(exp));
		sfp_master_i.frame({SFP_OP_RD_STATUS, 56'h0}, 3, 0, m, 1'b1);
	endtask
	task automatic unlock(input logic m);
		sfp_master_i.frame({SFP_OP_UNLOCK, 56'h0}, 1, 0, m, 1'b0);
	endtask
	task automatic page(input logic [7:0] op, input logic [15:0] pg, input logic [7:0] lo, input int nd,
		input int xb, input logic m);
		int i;
		for (i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			d[i] = rnd;
		end
		sfp_master_i.frame({op, pg, lo, d[0], d[1], d[2], 8'h00}, 4 + nd, xb, m, 1'b0);
	endtask
	task automatic buf_chk(input logic [7:0] a, input logic [8:0] exp);
		buf_rd_addr_in = a;
		sfp_master_i.tick(2);
		check(32'(buf_rd_out), 32'(exp));
	endtask
	// ----
	// result watcher and hang limit
	// ----
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
		if (commit_out.strobe === 1'b1) check(32'(commit_out), cq.size() ? cq.pop_front() : 32'hFFFFFFFF);
		if (rd_cnt !== rd_seen) begin
			rd_seen = rd_cnt;
			check(32'(rd_byte), sq.size() ? sq.pop_front() : 32'hFFFFFFFF);
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		sfp_master_i.tick(5);
		check(32'({serial_oe_n_out, standby_out, busy_out}), 32'h6);
		nrst_in = 1'b1;
		rdsr(8'h00, 1'b0);
		page(SFP_OP_BURN, 16'h0012, 8'hFF, 2, 0, 1'b0); // no latch, no commit expected
		unlock(1'b1);
		rdsr(8'h02, 1'b1);
		page(SFP_OP_BURN, 16'h0012, 8'hFF, 2, 3, 1'b1); // three stray clocks void it
		rdsr(8'h02, 1'b0);
		cq.push_back(32'({1'b1, 1'b0, 16'h0012}));
		page(SFP_OP_BURN, 16'h0012, 8'hFF, 2, 0, 1'b0);
		sfp_master_i.tick(40);
		check(32'(busy_out), 32'h0);
		buf_chk(8'hFF, {1'b1, d[0]});
		buf_chk(8'h00, {1'b1, d[1]}); // address wraps inside the page
		buf_rd_addr_in = 8'h01;
		sfp_master_i.tick(2);
		check(32'(buf_rd_out.mark), 32'h0);
		rnd = lfsr(rnd);
		buf_rd_addr_in = rnd;
		sfp_master_i.tick(2);
		check(32'(buf_rd_out.mark), 32'(rnd == 8'hFF || rnd == 8'h00));
		rdsr(8'h00, 1'b1); // latch cleared at completion
		unlock(1'b1);
		sfp_master_i.frame({SFP_OP_RELOCK, 56'h0}, 1, 0, 1'b0, 1'b0);
		rdsr(8'h00, 1'b0); // relock clears the latch
		unlock(1'b0);
		cq.push_back(32'({1'b1, 1'b1, 16'hABCD}));
		page(SFP_OP_REWRITE, 16'hABCD, 8'h10, 3, 0, 1'b1);
		sfp_master_i.tick(10);
		check(32'(busy_out), 32'h1);
		nrst_in = 1'b0;
		sfp_master_i.tick(2);
		check(32'({busy_out, serial_oe_n_out}), 32'h1);
		nrst_in = 1'b1;
		sfp_master_i.tick(30);
		check(32'(busy_out), 32'h0);
		rdsr(8'h00, 1'b0);
		rnd = lfsr(rnd);
		// freeze bit still clear, so either pin level must let the status write through
		wp_n_in = rnd[0];
		unlock(1'b1);
		sfp_master_i.frame({SFP_OP_WR_STATUS, 8'h9C, 48'h0}, 2, 0, 1'b1, 1'b0);
		rdsr(8'h9C, 1'b0);
		wp_n_in = 1'b0;
		unlock(1'b0);
		sfp_master_i.frame({SFP_OP_WR_STATUS, 8'h00, 48'h0}, 2, 0, 1'b0, 1'b0);
		rdsr(8'h9E, 1'b1); // frozen, latch still set
		wp_n_in = 1'b1;
		check(32'(cq.size() + sq.size()), 32'h0);
		summarize();
	end
endmodule
